// File: src/status_queue_pkg.sv
// holds: constants, enums and carriers shared by the status queues
// assumes: nothing beyond a SystemVerilog compiler
package status_queue_pkg;

  localparam int CODE_W = 16;
  localparam int MSG_W = 8;
  localparam int EQ_DEPTH = 10;
  localparam int OQ_DEPTH = 16;
  localparam int FLT_ENTRIES = 8;

  localparam logic [CODE_W-1:0] OVF_CODE = 16'h015E;
  localparam logic [CODE_W-1:0] NO_ERR_CODE = 16'h0000;
  localparam logic ERR_DFLT_ALLOW = 1'h1;
  localparam logic STS_DFLT_ALLOW = 1'h0;

  typedef enum logic [1:0] {
    FLT_NONE,
    FLT_ENA_BEGIN,
    FLT_ENA_ITEM,
    FLT_DIS_ITEM
  } flt_op_t;

  typedef struct packed {
    flt_op_t op;
    logic signed [CODE_W-1:0] lo;
    logic signed [CODE_W-1:0] hi;
  } flt_cmd_t;

  typedef struct packed {
    logic used;
    logic allow;
    logic signed [CODE_W-1:0] lo;
    logic signed [CODE_W-1:0] hi;
  } flt_entry_t;

  typedef struct packed {
    logic valid;
    logic status;
    logic signed [CODE_W-1:0] code;
  } err_evt_t;

  typedef struct packed {
    logic valid;
    logic all;
    logic code_only;
  } err_req_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic code_only;
    logic signed [CODE_W-1:0] code;
  } err_ans_t;

endpackage : status_queue_pkg

// File: src/queue_mem.sv
// holds: storage array of one queue, registered read port
// assumes: single clock, write and read addresses below DEPTH
`timescale 1ns/1ps
`default_nettype none

module queue_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("queue_mem needs depth two or more");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_reg[rd_addr_i];
  end

endmodule : queue_mem

`default_nettype wire

// File: src/code_filter.sv
// holds: admit filter of the error queue, ordered range list
// assumes: one command per cycle on cmd_i, same clock as the queue
`timescale 1ns/1ps
`default_nettype none

module code_filter #(
  parameter int ENTRIES = status_queue_pkg::FLT_ENTRIES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire status_queue_pkg::flt_cmd_t cmd_i,
  input wire logic signed [status_queue_pkg::CODE_W-1:0] code_i,
  input wire logic is_status_i,
  output logic admit_o,
  output logic full_o
);

  localparam int FA = $clog2(ENTRIES+1);
  localparam int CW = status_queue_pkg::CODE_W;

  if (ENTRIES < 1) begin : g_bad
    $error("code_filter needs at least one entry");
  end

  status_queue_pkg::flt_entry_t ent_reg [ENTRIES];
  logic [FA-1:0] fill_reg;
  logic err_dflt_reg;
  logic sts_dflt_reg;
  logic [ENTRIES-1:0] hit;
  logic item;
  logic wipe;
  logic signed [CW-1:0] lo;
  logic signed [CW-1:0] hi;

  assign wipe = cmd_i.op == status_queue_pkg::FLT_ENA_BEGIN;
  assign item = cmd_i.op == status_queue_pkg::FLT_ENA_ITEM
             || cmd_i.op == status_queue_pkg::FLT_DIS_ITEM;
  assign full_o = fill_reg == FA'(ENTRIES);
  assign lo = (cmd_i.lo <= cmd_i.hi) ? cmd_i.lo : cmd_i.hi;
  assign hi = (cmd_i.lo <= cmd_i.hi) ? cmd_i.hi : cmd_i.lo;

  ////////////////////////////////////////////////////////////////////////
  // class defaults and fill level

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_dflt_reg <= status_queue_pkg::ERR_DFLT_ALLOW;
      sts_dflt_reg <= status_queue_pkg::STS_DFLT_ALLOW;
    end else if (wipe) begin
      err_dflt_reg <= 1'h0;
      sts_dflt_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wipe) begin
      fill_reg <= '0;
    end else if (item && !full_o) begin
      fill_reg <= fill_reg + FA'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // range entries, later entries win

  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (rst_i || wipe) begin
        ent_reg[i] <= '0;
      end else if (item && !full_o && fill_reg == FA'(i)) begin
        ent_reg[i].used <= 1'h1;
        ent_reg[i].allow <= cmd_i.op == status_queue_pkg::FLT_ENA_ITEM;
        ent_reg[i].lo <= lo;
        ent_reg[i].hi <= hi;
      end
    end
    assign hit[i] = ent_reg[i].used && code_i >= ent_reg[i].lo
                 && code_i <= ent_reg[i].hi;
  end

  always_comb begin
    admit_o = is_status_i ? sts_dflt_reg : err_dflt_reg;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hit[i]) begin
        admit_o = ent_reg[i].allow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  ena_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wipe ##1 (cmd_i.op == status_queue_pkg::FLT_NONE) |-> !admit_o)
    else $error("empty enable list still admits");

endmodule : code_filter

`default_nettype wire

// File: src/status_message_queues.sv
// holds: output queue and error queue of the instrument status model
// assumes: one clock, command decoding and message text done outside
`timescale 1ns/1ps
`default_nettype none

module status_message_queues #(
  parameter int EQ_DEPTH = status_queue_pkg::EQ_DEPTH,
  parameter int OQ_DEPTH = status_queue_pkg::OQ_DEPTH,
  parameter int MSG_W = status_queue_pkg::MSG_W,
  parameter int FLT_ENTRIES = status_queue_pkg::FLT_ENTRIES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cls_i,
  input wire logic err_clear_i,
  input wire logic resp_valid_i,
  input wire logic [MSG_W-1:0] resp_data_i,
  output logic resp_ready_o,
  input wire logic talk_rd_i,
  output logic talk_ready_o,
  output logic resp_valid_o,
  output logic [MSG_W-1:0] resp_data_o,
  output logic message_available_flag_o,
  input wire status_queue_pkg::err_evt_t evt_i,
  input wire status_queue_pkg::flt_cmd_t flt_cmd_i,
  output logic flt_full_o,
  input wire status_queue_pkg::err_req_t err_req_i,
  output logic err_req_ready_o,
  output status_queue_pkg::err_ans_t err_ans_o,
  output logic [$clog2(EQ_DEPTH+1)-1:0] err_count_o,
  output logic error_available_flag_o
);

  localparam int CW = status_queue_pkg::CODE_W;
  localparam int OA = $clog2(OQ_DEPTH);
  localparam int OC = $clog2(OQ_DEPTH+1);
  localparam int EA = $clog2(EQ_DEPTH);
  localparam int EC = $clog2(EQ_DEPTH+1);
  localparam logic [OA-1:0] O_LAST = OA'(OQ_DEPTH-1);
  localparam logic [EA-1:0] E_LAST = EA'(EQ_DEPTH-1);
  localparam logic [OC-1:0] O_FULL = OC'(OQ_DEPTH);
  localparam logic [EC-1:0] E_FULL = EC'(EQ_DEPTH);
  localparam logic [EC-1:0] E_MARK = EC'(EQ_DEPTH-1);

  if (EQ_DEPTH < 2 || OQ_DEPTH < 2) begin : g_bad
    $error("queue depths must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////
  // output queue
  logic [OA-1:0] oq_head_reg, oq_tail_reg;
  logic [OC-1:0] oq_count_reg;
  logic [MSG_W-1:0] oq_rdata;
  logic oq_busy_reg, oq_push, oq_take, oq_pop;

  assign resp_ready_o = oq_count_reg != O_FULL;
  assign oq_push = resp_valid_i && resp_ready_o;
  assign talk_ready_o = !oq_busy_reg && oq_count_reg != '0;
  assign oq_take = talk_rd_i && talk_ready_o;
  assign oq_pop = oq_busy_reg;

  queue_mem #(
    .WIDTH(MSG_W),
    .DEPTH(OQ_DEPTH)
  ) u_oq_mem (
    .clk_i(clk_i),
    .wr_en_i(oq_push),
    .wr_addr_i(oq_tail_reg),
    .wr_data_i(resp_data_i),
    .rd_addr_i(oq_head_reg),
    .rd_data_o(oq_rdata)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oq_busy_reg <= 1'h0;
    end else begin
      oq_busy_reg <= oq_take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oq_head_reg <= '0;
      oq_tail_reg <= '0;
    end else begin
      if (oq_push) begin
        oq_tail_reg <= (oq_tail_reg == O_LAST) ? '0 : oq_tail_reg + OA'(1);
      end
      if (oq_pop) begin
        oq_head_reg <= (oq_head_reg == O_LAST) ? '0 : oq_head_reg + OA'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oq_count_reg <= '0;
    end else begin
      oq_count_reg <= oq_count_reg + OC'(oq_push) - OC'(oq_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'h0;
      resp_data_o <= '0;
    end else begin
      resp_valid_o <= oq_pop;
      if (oq_pop) begin
        resp_data_o <= oq_rdata;
      end
    end
  end

  assign message_available_flag_o = oq_count_reg != '0;

  ////////////////////////////////////////////////////////////////////////
  // error queue storage and filter
  logic admit, eq_clear, eq_push, eq_pop, eq_take, rd_last;
  logic [EA-1:0] eq_head_reg, eq_tail_reg;
  logic [EC-1:0] eq_count_reg, eq_count_next;
  logic [CW-1:0] eq_wdata, eq_rdata;

  code_filter #(
    .ENTRIES(FLT_ENTRIES)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_i(flt_cmd_i),
    .code_i(evt_i.code),
    .is_status_i(evt_i.status),
    .admit_o(admit),
    .full_o(flt_full_o)
  );

  assign eq_clear = cls_i || err_clear_i;
  assign eq_push = evt_i.valid && admit && !eq_clear
                && eq_count_reg != E_FULL;
  assign eq_wdata = (eq_count_reg == E_MARK)
                  ? status_queue_pkg::OVF_CODE : evt_i.code;

  queue_mem #(
    .WIDTH(CW),
    .DEPTH(EQ_DEPTH)
  ) u_eq_mem (
    .clk_i(clk_i),
    .wr_en_i(eq_push),
    .wr_addr_i(eq_tail_reg),
    .wr_data_i(eq_wdata),
    .rd_addr_i(eq_head_reg),
    .rd_data_o(eq_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // error queue read sequencer
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_EMIT,
    RD_SETTLE
  } rd_state_t;
  rd_state_t rd_state_reg, rd_state_next;
  logic rd_all_reg, rd_code_only_reg, rd_none_reg;
  assign err_req_ready_o = rd_state_reg == RD_IDLE && !eq_clear;
  assign eq_take = err_req_i.valid && err_req_ready_o;
  assign eq_pop = rd_state_reg == RD_EMIT && !rd_none_reg && !eq_clear;
  assign eq_count_next = eq_clear ? '0
    : eq_count_reg + EC'(eq_push) - EC'(eq_pop);
  assign rd_last = !rd_all_reg || rd_none_reg || eq_count_next == '0;

  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (eq_take) begin
          rd_state_next = RD_EMIT;
        end
      end
      RD_EMIT: begin
        rd_state_next = rd_last ? RD_IDLE : RD_SETTLE;
      end
      RD_SETTLE: begin
        rd_state_next = RD_EMIT;
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
    if (eq_clear) begin
      rd_state_next = RD_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_state_reg <= RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_all_reg <= 1'h0;
      rd_code_only_reg <= 1'h0;
      rd_none_reg <= 1'h0;
    end else if (eq_take) begin
      rd_all_reg <= err_req_i.all;
      rd_code_only_reg <= err_req_i.code_only;
      rd_none_reg <= eq_count_reg == '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_head_reg <= '0;
      eq_tail_reg <= '0;
    end else if (eq_clear) begin
      eq_head_reg <= '0;
      eq_tail_reg <= '0;
    end else begin
      if (eq_push) begin
        eq_tail_reg <= (eq_tail_reg == E_LAST) ? '0 : eq_tail_reg + EA'(1);
      end
      if (eq_pop) begin
        eq_head_reg <= (eq_head_reg == E_LAST) ? '0 : eq_head_reg + EA'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_count_reg <= '0;
    end else begin
      eq_count_reg <= eq_count_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_ans_o <= '0;
    end else begin
      err_ans_o.valid <= rd_state_reg == RD_EMIT && !eq_clear;
      if (rd_state_reg == RD_EMIT) begin
        err_ans_o.code <= rd_none_reg
          ? status_queue_pkg::NO_ERR_CODE : eq_rdata;
        err_ans_o.last <= rd_last;
        err_ans_o.code_only <= rd_code_only_reg;
      end
    end
  end

  assign err_count_o = eq_count_reg;
  assign error_available_flag_o = eq_count_reg != '0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  mav_set_a: assert property (
    oq_push |=> message_available_flag_o)
    else $error("response queued but flag low");
  mav_clear_a: assert property (
    oq_count_reg == OC'(1) && oq_pop && !oq_push
    |=> !message_available_flag_o && resp_valid_o)
    else $error("output queue empty but flag high");
  talk_fetch_a: assert property (
    oq_take |=> !talk_ready_o ##1 resp_valid_o)
    else $error("talk read did not answer in two cycles");
  eav_set_a: assert property (
    eq_push |=> error_available_flag_o && eq_count_reg != '0)
    else $error("error queued but flag low");
  eav_clear_a: assert property (
    eq_count_reg == EC'(1) && eq_pop && !eq_push
    |=> !error_available_flag_o)
    else $error("error queue empty but flag high");
  eq_depth_a: assert property (
    eq_count_reg <= E_FULL)
    else $error("error queue exceeds its depth");
  read_oldest_a: assert property (
    eq_pop && !eq_push |=> eq_count_reg == $past(eq_count_reg) - EC'(1)
    && err_ans_o.valid && err_ans_o.code == $past(eq_rdata))
    else $error("single read did not remove oldest");
  ovf_marker_a: assert property (
    eq_push && eq_count_reg == E_MARK && !eq_pop
    |-> eq_wdata == status_queue_pkg::OVF_CODE
    ##1 eq_count_reg == E_FULL)
    else $error("overflow marker not stored");
  empty_read_a: assert property (
    eq_take && eq_count_reg == '0 ##1 !eq_clear
    |=> err_ans_o.valid && err_ans_o.code == '0 && err_ans_o.last)
    else $error("empty read did not give code 0");
  clear_empty_a: assert property (
    eq_clear |=> eq_count_reg == '0 && !error_available_flag_o)
    else $error("clear left entries");
  full_discard_a: assert property (
    eq_count_reg == E_FULL && !eq_pop && !eq_clear
    |=> eq_count_reg == E_FULL)
    else $error("full queue took a message");
  cov_read_all_c: cover property (
    eq_take && err_req_i.all && eq_count_reg == EC'(3)
    ##[3:12] err_ans_o.valid && err_ans_o.last);
  cov_overflow_c: cover property (
    eq_push && eq_count_reg == E_MARK);
  cov_empty_read_c: cover property (
    err_ans_o.valid && err_ans_o.code == '0);
  cov_talk_c: cover property (
    oq_take ##2 resp_valid_o);

endmodule : status_message_queues

`default_nettype wire

// File: testbench/host_model.sv
// holds: remote host model, talk reads and error queue reads
// assumes: called just after a rising edge, one task at a time
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk_i,
  input wire logic talk_ready_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_data_i,
  input wire logic err_req_ready_i,
  input wire status_queue_pkg::err_ans_t err_ans_i,
  output logic talk_rd_o,
  output status_queue_pkg::err_req_t err_req_o
);
  logic co_bad = 1'b0;

  initial begin
    talk_rd_o = 1'b0;
    err_req_o = '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // talk read of one byte once a query has filled the output queue
  task automatic talk(output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = '0;
    @(posedge clk_i);
    talk_rd_o <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (talk_ready_i !== 1'b1 && n < 20);
    @(posedge clk_i);
    talk_rd_o <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      if (resp_valid_i === 1'b1) begin
        ok = 1'b1;
        data = resp_data_i;
      end
    end
  endtask : talk

  //////////////////////////////////////////////////////////////////////////
  // error queue read, single or all, collects codes until last
  task automatic err_read(input logic rd_all, input logic co,
                          output logic [15:0] q[$], output logic ok);
    int n;
    q = {};
    ok = 1'b0;
    @(posedge clk_i);
    err_req_o <= '{valid: 1'b1, all: rd_all, code_only: co};
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (err_req_ready_i !== 1'b1 && n < 20);
    @(posedge clk_i);
    err_req_o <= '0;
    for (n = 0; n < 60 && !ok; n++) begin
      @(negedge clk_i);
      if (err_ans_i.valid === 1'b1) begin
        q.push_back(err_ans_i.code);
        if (err_ans_i.code_only !== co) co_bad = 1'b1;
        ok = (err_ans_i.last === 1'b1);
      end
    end
  endtask : err_read
endmodule : host_model

`default_nettype wire

// File: testbench/tb_top.sv
// holds: self-checking testbench of the status message queues
// assumes: host_model stands in for the remote bus host
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst, cls, err_clear, resp_valid, resp_ready, talk_rd, talk_ready;
  logic resp_vld_out, message_available_flag, flt_full, err_req_ready, error_available_flag;
  logic [7:0] resp_data, resp_data_out;
  logic [3:0] err_count;
  status_queue_pkg::err_evt_t evt;
  status_queue_pkg::flt_cmd_t flt_cmd;
  status_queue_pkg::err_req_t err_req;
  status_queue_pkg::err_ans_t err_ans;
  int n_errors = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  status_message_queues DUT (.clk_i(clk), .rst_i(rst), .cls_i(cls),
    .err_clear_i(err_clear), .resp_valid_i(resp_valid),
    .resp_data_i(resp_data), .resp_ready_o(resp_ready),
    .talk_rd_i(talk_rd), .talk_ready_o(talk_ready),
    .resp_valid_o(resp_vld_out), .resp_data_o(resp_data_out),
    .message_available_flag_o(message_available_flag), .evt_i(evt), .flt_cmd_i(flt_cmd),
    .flt_full_o(flt_full), .err_req_i(err_req),
    .err_req_ready_o(err_req_ready), .err_ans_o(err_ans),
    .err_count_o(err_count), .error_available_flag_o(error_available_flag));

  host_model host (.clk_i(clk), .talk_ready_i(talk_ready),
    .resp_valid_i(resp_vld_out), .resp_data_i(resp_data_out),
    .err_req_ready_i(err_req_ready), .err_ans_i(err_ans),
    .talk_rd_o(talk_rd), .err_req_o(err_req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic need(input logic ok);
    check("handshake", 16'h0001, {15'h0000, ok});
    if (ok !== 1'b1) final_report();
  endtask : need

  task automatic cnt(input logic [3:0] e);
    @(negedge clk);
    check("count", {12'h000, e}, {12'h000, err_count});
    check("eav", {15'h0000, e != 4'h0}, {15'h0000, error_available_flag});
  endtask : cnt

  task automatic send(input logic st, input int codes[$]);
    @(posedge clk);
    foreach (codes[i]) begin
      evt <= '{valid: 1'b1, status: st, code: 16'(codes[i])};
      @(posedge clk);
    end
    evt <= '0;
  endtask : send

  task automatic flt(input status_queue_pkg::flt_op_t op, input int lo,
                     input int hi);
    @(posedge clk);
    flt_cmd <= '{op: op, lo: 16'(lo), hi: 16'(hi)};
    @(posedge clk);
    flt_cmd <= '0;
  endtask : flt

  task automatic rd_check(input logic all, input logic co, input int exp[$]);
    logic [15:0] q[$];
    logic ok;
    host.err_read(all, co, q, ok);
    need(ok);
    check("entries", 16'(exp.size()), 16'(q.size()));
    foreach (exp[i]) check("code", 16'(exp[i]), q[i]);
  endtask : rd_check

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge clk);
    check("mav", 16'h0000, {15'h0000, message_available_flag});
    check("resp_ready", 16'h0001, {15'h0000, resp_ready});
    cnt(4'h0);
    rd_check(1'b0, 1'b1, '{0});
  endtask : t_reset

  task automatic t_outq;
    logic [7:0] d;
    logic ok;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      resp_valid <= 1'b1;
      resp_data <= 8'hA0 + 8'(i);
      @(posedge clk);
    end
    resp_valid <= 1'b0;
    @(negedge clk);
    check("mav", 16'h0001, {15'h0000, message_available_flag});
    check("resp_ready", 16'h0000, {15'h0000, resp_ready});
    cnt(4'h0);
    for (int i = 0; i < 16; i++) begin
      host.talk(d, ok);
      need(ok);
      check("talk byte", {8'h00, 8'hA0 + 8'(i)}, {8'h00, d});
    end
    check("mav", 16'h0000, {15'h0000, message_available_flag});
  endtask : t_outq

  task automatic t_errq;
    send(1'b0, '{-1, -2, -3, -4, -5, -6, -7, -8, -9, -10, -11, -12});
    cnt(4'hA);
    rd_check(1'b0, 1'b0, '{-1});
    cnt(4'h9);
    rd_check(1'b1, 1'b1, '{-2, -3, -4, -5, -6, -7, -8, -9, 350});
    cnt(4'h0);
    check("echo", 16'h0000, {15'h0000, host.co_bad});
  endtask : t_errq

  task automatic t_filter;
    send(1'b1, '{5});
    cnt(4'h0);
    flt(status_queue_pkg::FLT_ENA_BEGIN, 0, 0);
    flt(status_queue_pkg::FLT_ENA_ITEM, -110, -222);
    flt(status_queue_pkg::FLT_ENA_ITEM, -5, -5);
    send(1'b0, '{-110, -222, -150, -100, -5, -300});
    cnt(4'h4);
    flt(status_queue_pkg::FLT_DIS_ITEM, -150, -150);
    send(1'b0, '{-150, -110});
    cnt(4'h5);
    rd_check(1'b1, 1'b0, '{-110, -222, -150, -5, -110});
    send(1'b1, '{-5});
    cnt(4'h1);
    @(posedge clk);
    cls <= 1'b1;
    @(posedge clk);
    cls <= 1'b0;
    cnt(4'h0);
    send(1'b0, '{-110, -1});
    cnt(4'h1);
    @(posedge clk);
    err_clear <= 1'b1;
    @(posedge clk);
    err_clear <= 1'b0;
    cnt(4'h0);
    flt(status_queue_pkg::FLT_ENA_BEGIN, 0, 0);
    send(1'b0, '{-110, -1});
    cnt(4'h0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    send(1'b0, '{-1});
    send(1'b1, '{-110});
    cnt(4'h1);
  endtask : t_filter

  // filter table fills up, a further item is refused
  task automatic t_flt_full;
    flt(status_queue_pkg::FLT_ENA_BEGIN, 0, 0);
    @(negedge clk);
    check("flt_full", 16'h0000, {15'h0000, flt_full});
    for (int i = 0; i < status_queue_pkg::FLT_ENTRIES; i++) begin
      flt(status_queue_pkg::FLT_ENA_ITEM, -20 - i, -20 - i);
    end
    @(negedge clk);
    check("flt_full", 16'h0001, {15'h0000, flt_full});
    flt(status_queue_pkg::FLT_ENA_ITEM, -7, -7);
    send(1'b0, '{-20, -27, -7});
    cnt(4'h3);
  endtask : t_flt_full

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cls = 1'b0;
    err_clear = 1'b0;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    evt = '0;
    flt_cmd = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_outq();
    t_errq();
    t_filter();
    t_flt_full();
    final_report();
  end
endmodule : tb_top

`default_nettype wire
